//--- mfd_regs.svh
`ifndef MFD_REGS_SVH
`define MFD_REGS_SVH
// register byte offsets on the AXI4-Lite slave
`define MFD_A_INSTR   8'h00
`define MFD_A_NEXT    8'h04
`define MFD_A_CTLW    8'h08
`define MFD_A_IPTR    8'h0C
`define MFD_A_INDEX1  8'h10
`define MFD_A_OPND    8'h14
`define MFD_A_PRIV    8'h18
`define MFD_A_LOCK    8'h1C
`define MFD_A_CLASS   8'h20
`define MFD_A_FIELDS  8'h24
`define MFD_A_TARGET  8'h28
`define MFD_A_IOCTL   8'h2C
`define MFD_A_IMM     8'h30
`define MFD_A_BUSADR  8'h34
`define MFD_A_RANGE   8'h38
// reset values
`define MFD_RST_WORD  16'h0000
`define MFD_RST_ADDR  24'h000000
`define MFD_RST_OPND  32'h00000000
// lock control bit positions
`define MFD_LK_ACQ    0
`define MFD_LK_REL    1
// decode constants
`define MFD_TRAP_VEC  8'h0D
`define MFD_IO_OPC_HI 2'h3
`define MFD_OPC_ADRNG 5'h1F
`define MFD_FC_LDADR  6'h09
`define MFD_SIMM_TAG  2'h3
// AXI responses
`define MFD_RESP_OK   2'h0
`define MFD_RESP_ERR  2'h2
`endif

//--- mfd_pkg.sv
package mfd_pkg;
    // instruction category, one bit per category
    typedef enum logic [7:0] {
        MFD_CAT_DBL  = 8'h01,
        MFD_CAT_SGL  = 8'h02,
        MFD_CAT_IO   = 8'h04,
        MFD_CAT_SIMM = 8'h08,
        MFD_CAT_BREG = 8'h10,
        MFD_CAT_BIND = 8'h20,
        MFD_CAT_SHF  = 8'h40,
        MFD_CAT_GEN  = 8'h80
    } mfd_cat_e;
    // address syllable form
    typedef enum logic [2:0] {
        MFD_AS_REG = 3'h1,
        MFD_AS_IMM = 3'h2,
        MFD_AS_MEM = 3'h4
    } mfd_as_e;
    // locked update ownership
    typedef enum logic [1:0] {
        MFD_LK_FREE = 2'h1,
        MFD_LK_HELD = 2'h2
    } mfd_lock_e;
    // i/o control word split into unit and function
    typedef struct packed {
        logic [9:0] unit;
        logic [5:0] func;
    } mfd_ioctl_s;
endpackage

//--- mfd_decoder.sv
// Overview of operation
// - unsigned byte in word: high half zero, value in low half
// - double word is 32-bit two's complement, sign in top bit
// - every word falls in exactly one of eight categories
// - address syllable is register, immediate operand or memory form
// - double operand: lead bit, register, op-code, address syllable
// - double operand op-code alone picks data, base or mode register
// - operand form labels come from the address syllable form
// - single operand: prefix 1000, op-code, address syllable
// - locked update by another processor held off until released
// - even function code moves data in, odd moves data out
// - control word embedded after instruction or fetched via syllable
// - address-and-range sends byte address and range value
// - i/o without privilege traps through vector 13
// - short immediate: register, 4-bit op-code, signed byte value
// - branch on register: register, op-code and displacement fields
// - branch on indicator: prefix 0000, op-code, displacement
// - short shift: type, distance, zero distance from index bits
// - long shift: type, 5-bit distance, zero distance from index
// - double shifts name register 3, 5 or 7 only
// - carry takes the last bit shifted out
// - zero effective distance clears carry and overflow
// - displacement 0, 1 or signed short offset selects the target
// - byte addresses on the system bus are 24 bits
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "mfd_regs.svh"
module mfd_decoder
    import mfd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

////////////////////////////////////////////////////////////////////////////
// helper functions

// classify an address syllable into its three forms
function automatic mfd_as_e mfd_as_form(input logic [6:0] s);
    if (s[6:4] == 3'h5 && !s[3] && s[2:0] != 3'h0) begin
        return MFD_AS_REG;
    end
    if (s[6:4] == 3'h7 && !s[3] && s[2:0] == 3'h0) begin
        return MFD_AS_IMM;
    end
    return MFD_AS_MEM;
endfunction

// byte-lane merge for partial writes
function automatic logic [31:0] mfd_merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
        if (st[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
        end
    end
    return r;
endfunction

// writable offsets
function automatic logic mfd_wr_ok(input logic [7:0] a);
    return a == `MFD_A_INSTR || a == `MFD_A_NEXT || a == `MFD_A_CTLW ||
           a == `MFD_A_IPTR || a == `MFD_A_INDEX1 || a == `MFD_A_OPND ||
           a == `MFD_A_PRIV || a == `MFD_A_LOCK;
endfunction

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write and read channel state

logic        aw_got_r;
logic [7:0]  aw_addr_r;
logic        w_got_r;
logic [31:0] w_data_r;
logic [3:0]  w_strb_r;
logic [7:0]  rd_addr;
logic [31:0] rd_data;
logic        rd_hit;

// write fires once both address and data are held
wire wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
wire wr_good = wr_fire && mfd_wr_ok(aw_addr_r);
wire [31:0] wd = w_data_r;

// address and data may arrive in either order
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        aw_addr_r     <= 8'h00;
        w_data_r      <= 32'h00000000;
        w_strb_r      <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `MFD_RESP_OK;
    end else begin
        s_axi_awready <= !aw_got_r && !s_axi_bvalid &&
                         !(s_axi_awready && s_axi_awvalid);
        s_axi_wready  <= !w_got_r && !s_axi_bvalid &&
                         !(s_axi_wready && s_axi_wvalid);
        if (s_axi_awready && s_axi_awvalid) begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wready && s_axi_wvalid) begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_good ? `MFD_RESP_OK : `MFD_RESP_ERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// read answers one cycle after the address is taken
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `MFD_RESP_OK;
    end else if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_hit ? `MFD_RESP_OK : `MFD_RESP_ERR;
    end else if (s_axi_rvalid) begin
        s_axi_rvalid  <= !s_axi_rready;
        s_axi_arready <= s_axi_rready;
    end else begin
        s_axi_arready <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////
// software-written registers

logic [15:0] instr_r;
logic [15:0] next_r;
logic [15:0] ctlw_r;
logic [23:0] iptr_r;
logic [15:0] index1_r;
logic [31:0] opnd_r;
logic        priv_r;

wire wr_instr  = wr_good && aw_addr_r == `MFD_A_INSTR;
wire wr_next   = wr_good && aw_addr_r == `MFD_A_NEXT;
wire wr_ctlw   = wr_good && aw_addr_r == `MFD_A_CTLW;
wire wr_iptr   = wr_good && aw_addr_r == `MFD_A_IPTR;
wire wr_index1 = wr_good && aw_addr_r == `MFD_A_INDEX1;
wire wr_opnd   = wr_good && aw_addr_r == `MFD_A_OPND;
wire wr_priv   = wr_good && aw_addr_r == `MFD_A_PRIV;
wire wr_lock   = wr_good && aw_addr_r == `MFD_A_LOCK;

wire [31:0] m_instr  = mfd_merge({16'h0000, instr_r}, wd, w_strb_r);
wire [31:0] m_next   = mfd_merge({16'h0000, next_r}, wd, w_strb_r);
wire [31:0] m_ctlw   = mfd_merge({16'h0000, ctlw_r}, wd, w_strb_r);
wire [31:0] m_iptr   = mfd_merge({8'h00, iptr_r}, wd, w_strb_r);
wire [31:0] m_index1 = mfd_merge({16'h0000, index1_r}, wd, w_strb_r);
wire [31:0] m_opnd   = mfd_merge(opnd_r, wd, w_strb_r);

// plain storage; the decode below reads these directly
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        instr_r  <= `MFD_RST_WORD;
        next_r   <= `MFD_RST_WORD;
        ctlw_r   <= `MFD_RST_WORD;
        iptr_r   <= `MFD_RST_ADDR;
        index1_r <= `MFD_RST_WORD;
        opnd_r   <= `MFD_RST_OPND;
        priv_r   <= 1'b0;
    end else begin
        if (wr_instr)  instr_r  <= m_instr[15:0];
        if (wr_next)   next_r   <= m_next[15:0];
        if (wr_ctlw)   ctlw_r   <= m_ctlw[15:0];
        if (wr_iptr)   iptr_r   <= m_iptr[23:0];
        if (wr_index1) index1_r <= m_index1[15:0];
        if (wr_opnd)   opnd_r   <= m_opnd;
        if (wr_priv && w_strb_r[0]) priv_r <= wd[0];
    end
end

////////////////////////////////////////////////////////////////////////////
// locked update arbitration between processors

mfd_lock_e  lock_st_r;
logic [1:0] lock_own_r;
logic       lock_grant_r;

wire       lk_acq = wr_lock && w_strb_r[0] && wd[`MFD_LK_ACQ];
wire       lk_rel = wr_lock && w_strb_r[0] && wd[`MFD_LK_REL];
wire [1:0] lk_id  = wd[5:4];
wire       lk_mine = lk_id == lock_own_r;

// a held lock refuses every other owner until its owner releases
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        lock_st_r    <= MFD_LK_FREE;
        lock_own_r   <= 2'h0;
        lock_grant_r <= 1'b0;
    end else begin
        case (lock_st_r)
            MFD_LK_FREE: begin
                if (lk_acq) begin
                    lock_st_r    <= MFD_LK_HELD;
                    lock_own_r   <= lk_id;
                    lock_grant_r <= 1'b1;
                end
            end
            MFD_LK_HELD: begin
                if (lk_rel && lk_mine) begin
                    lock_st_r <= MFD_LK_FREE;
                end else if (lk_acq) begin
                    lock_grant_r <= lk_mine;
                end
            end
            default: begin
                lock_st_r <= MFD_LK_FREE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// category decode; fixed priority keeps categories exclusive

wire [15:0] iw  = instr_r;
wire [2:0]  rn  = iw[14:12];
wire [4:0]  opc = iw[11:7];
wire [6:0]  syl = iw[6:0];

wire is_gen  = iw[15:7] == 9'h000;
wire is_bind = iw[15:12] == 4'h0;
wire is_spfx = iw[15:12] == 4'h8;
wire is_io   = is_spfx && opc[4:3] == `MFD_IO_OPC_HI;
wire is_shf  = !iw[15] && iw[11:8] == 4'h0;
wire is_simm = !iw[15] && iw[11:10] == `MFD_SIMM_TAG;

// zero and 1000 prefixes are tested before the register forms
wire mfd_cat_e cat = is_gen  ? MFD_CAT_GEN :
                     is_bind ? MFD_CAT_BIND :
                     is_io   ? MFD_CAT_IO :
                     is_spfx ? MFD_CAT_SGL :
                     iw[15]  ? MFD_CAT_DBL :
                     is_shf  ? MFD_CAT_SHF :
                     is_simm ? MFD_CAT_SIMM :
                               MFD_CAT_BREG;

wire mfd_as_e as_form = mfd_as_form(syl);
wire has_as = cat == MFD_CAT_DBL || cat == MFD_CAT_SGL ||
              cat == MFD_CAT_IO;

// register kind from op-code: 0 data, 1 base, 2 mode
wire [1:0] reg_kind = (cat == MFD_CAT_DBL && opc[4:3] != 2'h3) ?
                      opc[4:3] : 2'h0;

// op-code field is four bits for short immediate
wire [4:0] opc_f = (cat == MFD_CAT_SIMM) ? {1'b0, iw[11:8]} : opc;

////////////////////////////////////////////////////////////////////////////
// short immediate value

wire [15:0] imm_sx = {{8{iw[7]}}, iw[7:0]};
wire [15:0] imm_zx = {8'h00, iw[7:0]};

////////////////////////////////////////////////////////////////////////////
// branch target from the displacement field

wire [23:0] d_sx   = {{17{syl[6]}}, syl};
wire [23:0] nx_sx  = {{8{next_r[15]}}, next_r};
wire [23:0] br_tgt = (syl == 7'h00) ? {8'h00, next_r} :
                     (syl == 7'h01) ? iptr_r + nx_sx :
                                      iptr_r + d_sx;

////////////////////////////////////////////////////////////////////////////
// shift distance and carry

wire       shf_long = iw[7];
wire [4:0] dist_f   = shf_long ? iw[4:0] : {1'b0, iw[3:0]};
wire [4:0] dist_x   = shf_long ? index1_r[4:0] : {1'b0, index1_r[3:0]};
wire [4:0] dist_eff = (dist_f != 5'h00) ? dist_f : dist_x;
wire       shf_rt   = shf_long ? iw[5] : iw[4];
wire [2:0] shf_type = shf_long ? {1'b0, iw[6:5]} : iw[6:4];
wire [31:0] shf_src = shf_long ? opnd_r : {16'h0000, opnd_r[15:0]};
wire [5:0] shf_w    = shf_long ? 6'h20 : 6'h10;
wire [5:0] out_k    = shf_rt ? {1'b0, dist_eff} - 6'h01 :
                               shf_w - {1'b0, dist_eff};
// a zero distance gives no shifted-out bit, so both indicators clear
wire carry   = (dist_eff != 5'h00) && shf_src[out_k[4:0]];
wire ovf_clr = dist_eff == 5'h00;
wire dw_neg  = opnd_r[31];

// long shifts link a register pair named by its odd member
wire pair_ok  = rn == 3'h3 || rn == 3'h5 || rn == 3'h7;
wire pair_bad = cat == MFD_CAT_SHF && shf_long && !pair_ok;

////////////////////////////////////////////////////////////////////////////
// i/o control word, direction, privilege and range output

wire        cw_embed = next_r[15:7] != 9'h000;
wire mfd_ioctl_s cw  = cw_embed ? next_r : ctlw_r;
wire        to_ctrl  = cw.func[0];
wire        is_ar    = cat == MFD_CAT_IO && opc == `MFD_OPC_ADRNG;
wire        ar_bad   = is_ar && cw.func != `MFD_FC_LDADR;
wire        unspec   = pair_bad || ar_bad;
wire        trap     = cat == MFD_CAT_IO && !priv_r;
wire [7:0]  trap_vec = trap ? `MFD_TRAP_VEC : 8'h00;
wire        ar_valid = is_ar && !ar_bad && priv_r;
// word address from the output syllable becomes a byte address
wire [23:0] bus_adr  = {7'h00, next_r, 1'b0};
wire [15:0] range_w  = opnd_r[15:0];

////////////////////////////////////////////////////////////////////////////
// read selection

assign rd_addr = s_axi_araddr;

always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h00000000;
    case (rd_addr)
        `MFD_A_INSTR:  rd_data = {16'h0000, instr_r};
        `MFD_A_NEXT:   rd_data = {16'h0000, next_r};
        `MFD_A_CTLW:   rd_data = {16'h0000, ctlw_r};
        `MFD_A_IPTR:   rd_data = {8'h00, iptr_r};
        `MFD_A_INDEX1: rd_data = {16'h0000, index1_r};
        `MFD_A_OPND:   rd_data = opnd_r;
        `MFD_A_PRIV:   rd_data = {31'h0, priv_r};
        `MFD_A_LOCK:   rd_data = {23'h0, lock_grant_r, 2'h0, lock_own_r,
                                  3'h0, lock_st_r == MFD_LK_HELD};
        `MFD_A_CLASS:  rd_data = {trap_vec, 7'h00, dw_neg, unspec, trap,
                                  reg_kind, has_as, as_form, cat};
        `MFD_A_FIELDS: rd_data = {ovf_clr, carry, shf_rt, shf_long,
                                  1'b0, shf_type, 3'h0, dist_eff, 1'b0,
                                  syl, opc_f, rn};
        `MFD_A_TARGET: rd_data = {8'h00, br_tgt};
        `MFD_A_IOCTL:  rd_data = {14'h0, cw_embed, to_ctrl, cw};
        `MFD_A_IMM:    rd_data = {imm_zx, imm_sx};
        `MFD_A_BUSADR: rd_data = {8'h00, bus_adr};
        `MFD_A_RANGE:  rd_data = {15'h0, ar_valid, range_w};
        default: begin
            rd_hit  = 1'b0;
            rd_data = 32'h00000000;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////
// assertions

default clocking mfd_cb @(posedge aclk);
endclocking
default disable iff (!aresetn);

AST_CAT_ONEHOT: assert property ($onehot(cat))
    else $error("category not one-hot");
AST_DBL_FIELDS: assert property (iw[15] && !is_spfx |->
    cat == MFD_CAT_DBL && opc_f == iw[11:7] && rn == iw[14:12])
    else $error("double operand fields wrong");
AST_ZERO_FIRST: assert property (iw[15:12] == 4'h0 |->
    cat inside {MFD_CAT_GEN, MFD_CAT_BIND})
    else $error("zero prefix not matched first");
AST_IO_TRAP: assert property (cat == MFD_CAT_IO && !priv_r |->
    trap && trap_vec == 8'h0D && !ar_valid)
    else $error("missing i/o trap");
AST_IO_DIR: assert property (wr_ctlw ##1 cat == MFD_CAT_IO &&
    !cw_embed |-> to_ctrl == ctlw_r[0])
    else $error("i/o direction wrong");
AST_SHF_ZERO: assert property (cat == MFD_CAT_SHF &&
    dist_eff == 5'h00 |-> !carry && ovf_clr)
    else $error("indicator not cleared on zero shift");
AST_SHF_SUBST: assert property (cat == MFD_CAT_SHF && !iw[7] &&
    iw[3:0] == 4'h0 |-> dist_eff == {1'b0, index1_r[3:0]})
    else $error("short distance not substituted");
AST_PAIR_BAD: assert property (cat == MFD_CAT_SHF && iw[7] &&
    !(rn inside {3'h3, 3'h5, 3'h7}) |-> unspec)
    else $error("bad pair not flagged");
AST_BR_SHORT: assert property (syl > 7'h01 |->
    br_tgt == iptr_r + {{17{syl[6]}}, syl})
    else $error("short branch target wrong");
AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
AST_LOCK_HOLD: assert property (lock_st_r == MFD_LK_HELD &&
    lk_acq && !lk_mine && !lk_rel |=>
    lock_st_r == MFD_LK_HELD && !lock_grant_r &&
    lock_own_r == $past(lock_own_r))
    else $error("locked update not held off");

endmodule

//--- mfd_host.sv
`timescale 1ns/1ps
// register-bus master standing in for the fetch and execution side
module mfd_host (
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // bus idle from time zero so nothing is offered during reset
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one write: address and data together, each dropped once taken;
    // released lines are inverted so a stale value is never trusted
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~v;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // one read; answer taken at the edge where rvalid is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`include "mfd_regs.svh"
// compare, count, and report a mismatch at once
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
$display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench
    import mfd_pkg::*;
;
    typedef struct packed {
        logic [15:0] ins;
        logic [7:0]  cat;
    } mfd_row_s;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, c;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [15:0] x;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          failures = 0;
    int          n_tests = 0;
    int          cyc = 0;
    // one word of each category beside the category it decodes to
    mfd_row_s    rows [8] = '{
        '{16'h0005, MFD_CAT_GEN}, '{16'h0123, MFD_CAT_BIND},
        '{16'h8C05, MFD_CAT_IO}, '{16'h8205, MFD_CAT_SGL},
        '{16'hA4C5, MFD_CAT_DBL}, '{16'h3013, MFD_CAT_SHF},
        '{16'h2C85, MFD_CAT_SIMM}, '{16'h2445, MFD_CAT_BREG}};
    logic [15:0] as_in [3] = '{16'hA451, 16'hA870, 16'hA041};
    logic [31:0] as_ex [3] = '{32'h1900, 32'h2A00, 32'h0C00};
    logic [15:0] tg_in [3] = '{16'h2445, 16'h2401, 16'h2400};
    logic [15:0] tg_nx [3] = '{16'h0000, 16'hFFF0, 16'h1234};
    logic [31:0] tg_ex [3] = '{32'h000FC5, 32'h000FF0, 32'h001234};
    always #12.5 aclk = ~aclk;
    mfd_decoder i_mfd_decoder (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    mfd_host i_mfd_host (.aclk, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // a stalled handshake would otherwise hang the run
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            final_report();
        end
    end
    task automatic w(input logic [7:0] a, input logic [31:0] v);
        i_mfd_host.wr(a, v, r);
    endtask
    // masked register read against an expected word
    task automatic chk(input string n, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e);
        i_mfd_host.rd(a, d, r);
        `CHK(n, e, d & m)
    endtask
    // register, op-code and syllable fields in their fixed places
    function automatic logic [31:0] fld(input logic [15:0] v);
        return {17'h0, v[6:0], v[11:7], v[14:12]};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        chk("instr rst", `MFD_A_INSTR, 32'hFFFF, 32'h0);
        i_mfd_host.rd(8'h3C, d, r);
        `CHK("rd unmapped", 34'h200000000, {r, d})
        i_mfd_host.wr(`MFD_A_CLASS, 32'h1, r);
        `CHK("wr readonly", 2'h2, r)
        foreach (rows[i]) begin
            x = rows[i].ins;
            c = rows[i].cat;
            w(`MFD_A_INSTR, {16'h0, x});
            chk("cat", `MFD_A_CLASS, 32'hFF, {24'h0, c});
            if (|(c & 8'h33))
                chk("fld", `MFD_A_FIELDS, 32'h7FFF, fld(x));
        end
        // syllable form and register kind of double-operand words
        foreach (as_in[i]) begin
            w(`MFD_A_INSTR, {16'h0, as_in[i]});
            chk("form", `MFD_A_CLASS, 32'h3F00, as_ex[i]);
        end
        w(`MFD_A_INSTR, 32'h8C05);
        chk("trap", `MFD_A_CLASS, 32'hFF004000, 32'h0D004000);
        w(`MFD_A_PRIV, 32'h1);
        chk("no trap", `MFD_A_CLASS, 32'hFF004000, 32'h0);
        w(`MFD_A_NEXT, 32'h0483);
        chk("ctl emb", `MFD_A_IOCTL, 32'h3FFFF, 32'h30483);
        w(`MFD_A_NEXT, 32'h0);
        w(`MFD_A_CTLW, 32'h0042);
        chk("ctl loc", `MFD_A_IOCTL, 32'h3FFFF, 32'h00042);
        w(`MFD_A_INSTR, 32'h2C85);
        chk("imm neg", `MFD_A_IMM, 32'hFFFFFFFF, 32'h0085FF85);
        w(`MFD_A_INSTR, 32'h2C7F);
        chk("imm pos", `MFD_A_IMM, 32'hFFFFFFFF, 32'h007F007F);
        // branch target for displacement 0, 1 and a short offset
        w(`MFD_A_IPTR, 32'h001000);
        foreach (tg_in[i]) begin
            w(`MFD_A_INSTR, {16'h0, tg_in[i]});
            w(`MFD_A_NEXT, {16'h0, tg_nx[i]});
            chk("target", `MFD_A_TARGET, 32'hFFFFFF, tg_ex[i]);
        end
        w(`MFD_A_INDEX1, 32'h0007);
        w(`MFD_A_OPND, 32'h0004);
        w(`MFD_A_INSTR, 32'h3013);
        chk("shift", `MFD_A_FIELDS, 32'h771F0000, 32'h61030000);
        w(`MFD_A_INSTR, 32'h3000);
        chk("dist idx", `MFD_A_FIELDS, 32'h101F0000, 32'h00070000);
        w(`MFD_A_INDEX1, 32'h0);
        chk("dist 0", `MFD_A_FIELDS, 32'hC01F0000, 32'h80000000);
        w(`MFD_A_INDEX1, 32'h0013);
        w(`MFD_A_INSTR, 32'h3080);
        chk("long", `MFD_A_FIELDS, 32'h101F0000, 32'h10130000);
        chk("pair ok", `MFD_A_CLASS, 32'h8000, 32'h0);
        w(`MFD_A_INSTR, 32'h2080);
        chk("pair bad", `MFD_A_CLASS, 32'h8000, 32'h8000);
        // address-and-range output with the load-address function
        w(`MFD_A_INSTR, 32'h8F85);
        w(`MFD_A_NEXT, 32'h0489);
        chk("range", `MFD_A_RANGE, 32'h1FFFF, 32'h10004);
        chk("busadr", `MFD_A_BUSADR, 32'hFFFFFFFF, 32'h000912);
        w(`MFD_A_NEXT, 32'h048A);
        chk("bad func", `MFD_A_CLASS, 32'h8000, 32'h8000);
        w(`MFD_A_OPND, 32'h80000000);
        chk("dw sign", `MFD_A_CLASS, 32'h10000, 32'h10000);
        w(`MFD_A_OPND, 32'h7FFFFFFF);
        chk("dw pos", `MFD_A_CLASS, 32'h10000, 32'h0);
        // a second owner must be held off until the first releases
        w(`MFD_A_LOCK, 32'h01);
        chk("lock", `MFD_A_LOCK, 32'h131, 32'h101);
        w(`MFD_A_LOCK, 32'h11);
        chk("held off", `MFD_A_LOCK, 32'h131, 32'h001);
        w(`MFD_A_LOCK, 32'h02);
        chk("freed", `MFD_A_LOCK, 32'h1, 32'h0);
        // a reset in mid-run must clear privilege and the operand again
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk("opnd rst", `MFD_A_OPND, 32'hFFFFFFFF, 32'h0);
        chk("priv rst", `MFD_A_PRIV, 32'h1, 32'h0);
        final_report();
    end
endmodule
